// ### design/decoder_map.vh
// constants shared by the memory-type decoder files
// assumes inclusion by bare name
`ifndef DECODER_MAP_VH
`define DECODER_MAP_VH

// ==================================================================
// type codes held in the low field bits
`define TYPE_UNCACHEABLE      3'h0
`define TYPE_WRITE_COMBINING  3'h1
`define TYPE_WRITE_THROUGH    3'h4
`define TYPE_WRITE_PROTECT    3'h5
`define TYPE_WRITE_BACK       3'h6

// ==================================================================
// restriction ranks, lower is more restrictive
`define RANK_UNCACHEABLE      3'h0
`define RANK_WRITE_COMBINING  3'h1
`define RANK_WRITE_PROTECT    3'h2
`define RANK_WRITE_THROUGH    3'h3
`define RANK_WRITE_BACK       3'h4

// ==================================================================
// type field layout
`define FIELD_CODE_MSB        2
`define FIELD_CODE_LSB        0
`define FIELD_READ_MEM_BIT    4
`define FIELD_WRITE_MEM_BIT   3
`define FIELD_STD_RSVD_MSB    7
`define FIELD_STD_RSVD_LSB    3
`define FIELD_EXT_RSVD_MSB    7
`define FIELD_EXT_RSVD_LSB    5

// ==================================================================
// register byte offsets
`define OFF_CONTROL           32'h00000000
`define OFF_STATUS            32'h00000004
`define OFF_PROBE_FIELD       32'h00000008
`define OFF_PROBE_RESULT      32'h0000000c

// control bits
`define CTRL_TYPING_EN        0
`define CTRL_EXTENDED_EN      1
`define CTRL_CACHE_DISABLE    2
`define CTRL_PAGE_MERGE_EN    3
`define CTRL_MSB              3
`define CTRL_RESET            4'h0

// status bits
`define STAT_TYPE_MSB         2
`define STAT_TYPE_LSB         0
`define STAT_CACHEABLE        3
`define STAT_INVALID_NOW      4
`define STAT_RESERVED_NOW     5
`define STAT_INVALID_SEEN     8
`define STAT_RESERVED_SEEN    9

// probe field and probe result bits
`define PROBE_FIELD_MSB       7
`define PROBE_FIXED_BIT       8
`define PROBE_MSB             8
`define PROBE_RESET           9'h000
`define RES_TYPE_MSB          2
`define RES_TYPE_LSB          0
`define RES_INVALID           3
`define RES_RESERVED          4
`define RES_READ_MEM          5
`define RES_WRITE_MEM         6
`define RES_EXTENDED          7

// bus answers
`define RESP_OKAY             2'h0
`define RESP_SLVERR           2'h2
`define WORD_ZERO             32'h00000000
`define WORD_LSB_MASK         32'hfffffffc
`endif

// ### design/type_decode.v
// combinational decode of one eight-bit memory type field
// assumes the field is stable for the cycle in which it is sampled
`timescale 1ns/1ns
`include "decoder_map.vh"

module type_decode (
  input  wire [7:0] field,
  input  wire       fixed_range,
  input  wire       extended_enable,
  output reg  [2:0] mem_type,
  output reg        invalid_code,
  output reg        reserved_set,
  output reg        read_to_memory_select,
  output reg        write_to_memory_select,
  output reg        extended_used
);

  // ==================================================================
  // decode
  always @* begin
    // variable ranges never see the extended bits
    extended_used = extended_enable & fixed_range;
    invalid_code  = 1'b0;
    case (field[`FIELD_CODE_MSB:`FIELD_CODE_LSB])
      `TYPE_UNCACHEABLE:     mem_type = `TYPE_UNCACHEABLE;
      `TYPE_WRITE_COMBINING: mem_type = `TYPE_WRITE_COMBINING;
      `TYPE_WRITE_THROUGH:   mem_type = `TYPE_WRITE_THROUGH;
      `TYPE_WRITE_PROTECT:   mem_type = `TYPE_WRITE_PROTECT;
      `TYPE_WRITE_BACK:      mem_type = `TYPE_WRITE_BACK;
      default: begin
        mem_type     = `TYPE_UNCACHEABLE;
        invalid_code = 1'b1;
      end
    endcase
    if (extended_used) begin
      reserved_set           = |field[`FIELD_EXT_RSVD_MSB:`FIELD_EXT_RSVD_LSB];
      read_to_memory_select  = field[`FIELD_READ_MEM_BIT];
      write_to_memory_select = field[`FIELD_WRITE_MEM_BIT];
    end else begin
      // reserved bits are only reported, the code bits still decode
      reserved_set           = |field[`FIELD_STD_RSVD_MSB:`FIELD_STD_RSVD_LSB];
      read_to_memory_select  = 1'b0;
      write_to_memory_select = 1'b0;
    end
  end

endmodule // type_decode

// ### design/precedence_merge.v
// picks the more restrictive of the range type and a page-level type
// assumes the range type is already one of the five defined codes
`timescale 1ns/1ns
`include "decoder_map.vh"

module precedence_merge (
  input  wire [2:0] range_type,
  input  wire [2:0] page_type,
  input  wire       page_valid,
  output reg  [2:0] merged_type
);

  // ==================================================================
  // rank
  function [2:0] rank;
    input [2:0] t;
    begin
      case (t)
        `TYPE_WRITE_COMBINING: rank = `RANK_WRITE_COMBINING;
        `TYPE_WRITE_PROTECT:   rank = `RANK_WRITE_PROTECT;
        `TYPE_WRITE_THROUGH:   rank = `RANK_WRITE_THROUGH;
        `TYPE_WRITE_BACK:      rank = `RANK_WRITE_BACK;
        default:               rank = `RANK_UNCACHEABLE;
      endcase
    end
  endfunction

  // ==================================================================
  // merge
  always @* begin
    merged_type = range_type;
    if (page_valid && (rank(page_type) < rank(range_type))) begin
      // undefined page codes rank as uncacheable, so emit the clean code
      if (rank(page_type) == `RANK_UNCACHEABLE) begin
        merged_type = `TYPE_UNCACHEABLE;
      end else begin
        merged_type = page_type;
      end
    end
  end

endmodule // precedence_merge

// ### design/memory_type_field_decoder.v
// memory type field decoder with an axi4-lite control slave
// assumes the range field and page type come from logic on aclk
//
// Notes on behaviour
// - the memory type is taken from field bits 2:0 in both encodings
// - extended encoding: bits 7:5 reserved, bit 4 read select, bit 3 write select
// - extended encoding is honoured for fixed ranges only, never variable ranges
// - without explicit extended enable only the standard type values are used
// - code 00h: not cached, no write combining, no speculation
// - code 01h: not cached, writes combine, speculative reads allowed
// - code 04h: read miss allocates, write miss not, write hit updates memory too
// - code 05h: read miss allocates, writes to memory, write hit invalidates line
// - code 06h: read miss allocates any state, write miss allocates modified
// - range typing disabled makes every access uncacheable regardless of cache enable
// - caching only when the range registers assign a cacheable type
// - when mechanisms disagree the most restrictive type wins
//
// Register access over AXI4-Lite and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`include "decoder_map.vh"

module memory_type_field_decoder (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [31:0] awaddr,
  input  wire [2:0]  awprot,
  input  wire        awvalid,
  output reg         awready,
  input  wire [31:0] wdata,
  input  wire [3:0]  wstrb,
  input  wire        wvalid,
  output reg         wready,
  output reg  [1:0]  bresp,
  output reg         bvalid,
  input  wire        bready,
  input  wire [31:0] araddr,
  input  wire [2:0]  arprot,
  input  wire        arvalid,
  output reg         arready,
  output reg  [31:0] rdata,
  output reg  [1:0]  rresp,
  output reg         rvalid,
  input  wire        rready,
  input  wire [7:0]  range_type_field,
  input  wire        range_is_fixed,
  input  wire [2:0]  page_type,
  input  wire        page_type_valid,
  output reg  [2:0]  effective_type,
  output reg         access_cacheable,
  output reg         write_combine_allowed,
  output reg         speculative_read_allowed,
  output reg         read_miss_allocate,
  output reg         write_miss_allocate,
  output reg         read_alloc_any_state,
  output reg         write_hit_updates_memory,
  output reg         write_hit_invalidates,
  output reg         read_to_memory_select,
  output reg         write_to_memory_select,
  output reg         invalid_encoding
);

  // ==================================================================
  // functions
  function is_cacheable_type;
    input [2:0] t;
    begin
      is_cacheable_type = (t == `TYPE_WRITE_THROUGH) ||
                          (t == `TYPE_WRITE_PROTECT) ||
                          (t == `TYPE_WRITE_BACK);
    end
  endfunction

  function [31:0] apply_strobes;
    input [31:0] old_word;
    input [31:0] new_word;
    input [3:0]  strb;
    integer i;
    begin
      apply_strobes = old_word;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          apply_strobes[i*8 +: 8] = new_word[i*8 +: 8];
        end
      end
    end
  endfunction

  // ==================================================================
  // registers and internal state
  reg  [`CTRL_MSB:0]  control;
  reg  [`PROBE_MSB:0] probe_field;
  reg                 invalid_seen;
  reg                 reserved_seen;
  reg                 reserved_now;
  reg  [31:0]         aw_addr_q;
  reg  [31:0]         w_data_q;
  reg  [3:0]          w_strb_q;

  wire [2:0]          range_code;
  wire                range_invalid;
  wire                range_reserved;
  wire                range_read_sel;
  wire                range_write_sel;
  wire [2:0]          merged_type;
  wire [2:0]          probe_code;
  wire                probe_invalid;
  wire                probe_reserved;
  wire                probe_read_sel;
  wire                probe_write_sel;
  wire                probe_extended;

  wire                typing_en;
  wire                write_fire;
  wire [31:0]         write_word;
  wire [31:0]         control_word;
  wire [31:0]         probe_word;

  reg  [2:0]          next_type;
  reg                 next_cacheable;
  reg                 next_invalid_seen;
  reg                 next_reserved_seen;
  reg  [31:0]         read_word;
  reg                 read_hit;
  reg                 write_hit;

  assign typing_en = control[`CTRL_TYPING_EN];

  // ==================================================================
  // range field decode and precedence
  type_decode u_range_decode (
    .field                  (range_type_field),
    .fixed_range            (range_is_fixed),
    .extended_enable        (control[`CTRL_EXTENDED_EN]),
    .mem_type               (range_code),
    .invalid_code           (range_invalid),
    .reserved_set           (range_reserved),
    .read_to_memory_select  (range_read_sel),
    .write_to_memory_select (range_write_sel),
    .extended_used          ()
  );

  // page types only tighten the range type
  precedence_merge u_merge (
    .range_type  (range_code),
    .page_type   (page_type),
    .page_valid  (page_type_valid & control[`CTRL_PAGE_MERGE_EN]),
    .merged_type (merged_type)
  );

  // probe: firmware checks a field before loading it
  type_decode u_probe_decode (
    .field                  (probe_field[`PROBE_FIELD_MSB:0]),
    .fixed_range            (probe_field[`PROBE_FIXED_BIT]),
    .extended_enable        (control[`CTRL_EXTENDED_EN]),
    .mem_type               (probe_code),
    .invalid_code           (probe_invalid),
    .reserved_set           (probe_reserved),
    .read_to_memory_select  (probe_read_sel),
    .write_to_memory_select (probe_write_sel),
    .extended_used          (probe_extended)
  );

  // ==================================================================
  // effective type
  always @* begin
    if (typing_en) begin
      next_type = merged_type;
    end else begin
      next_type = `TYPE_UNCACHEABLE;
    end
    // typing off blocks caching even while caches are on
    next_cacheable = typing_en & ~control[`CTRL_CACHE_DISABLE] &
                     is_cacheable_type(next_type);
  end

  // ==================================================================
  // attribute outputs, one cycle after the inputs
  always @(posedge aclk) begin
    if (!aresetn) begin
      effective_type           <= `TYPE_UNCACHEABLE;
      access_cacheable         <= 1'b0;
      write_combine_allowed    <= 1'b0;
      speculative_read_allowed <= 1'b0;
      read_miss_allocate       <= 1'b0;
      write_miss_allocate      <= 1'b0;
      read_alloc_any_state     <= 1'b0;
      write_hit_updates_memory <= 1'b0;
      write_hit_invalidates    <= 1'b0;
      read_to_memory_select    <= 1'b0;
      write_to_memory_select   <= 1'b0;
      invalid_encoding         <= 1'b0;
      reserved_now             <= 1'b0;
    end else begin
      effective_type           <= next_type;
      access_cacheable         <= next_cacheable;
      write_combine_allowed    <= (next_type == `TYPE_WRITE_COMBINING);
      // uncacheable alone forbids speculation
      speculative_read_allowed <= (next_type != `TYPE_UNCACHEABLE);
      read_miss_allocate       <= next_cacheable;
      write_miss_allocate      <= next_cacheable &
                                  (next_type == `TYPE_WRITE_BACK);
      read_alloc_any_state     <= next_cacheable &
                                  (next_type == `TYPE_WRITE_BACK);
      write_hit_updates_memory <= (next_type == `TYPE_WRITE_THROUGH) ||
                                  (next_type == `TYPE_WRITE_PROTECT);
      write_hit_invalidates    <= next_cacheable &
                                  (next_type == `TYPE_WRITE_PROTECT);
      read_to_memory_select    <= typing_en & range_read_sel;
      write_to_memory_select   <= typing_en & range_write_sel;
      invalid_encoding         <= typing_en & range_invalid;
      reserved_now             <= typing_en & range_reserved;
    end
  end

  // ==================================================================
  // write channel
  // both channels are latched first, so address and data may come in any order
  assign write_fire   = ~awready & ~wready & ~bvalid;
  assign write_word   = apply_strobes(`WORD_ZERO, w_data_q, w_strb_q);
  assign control_word = apply_strobes({{(31-`CTRL_MSB){1'b0}}, control}, w_data_q, w_strb_q);
  assign probe_word   = apply_strobes({{(31-`PROBE_MSB){1'b0}}, probe_field}, w_data_q, w_strb_q);

  always @* begin
    case (aw_addr_q & `WORD_LSB_MASK)
      `OFF_CONTROL:     write_hit = 1'b1;
      `OFF_STATUS:      write_hit = 1'b1;
      `OFF_PROBE_FIELD: write_hit = 1'b1;
      default:          write_hit = 1'b0;
    endcase
  end

  // sticky flags: a new event in the clearing cycle survives the clear
  always @* begin
    next_invalid_seen  = invalid_seen;
    next_reserved_seen = reserved_seen;
    if (write_fire && ((aw_addr_q & `WORD_LSB_MASK) == `OFF_STATUS)) begin
      if (write_word[`STAT_INVALID_SEEN]) begin
        next_invalid_seen = 1'b0;
      end
      if (write_word[`STAT_RESERVED_SEEN]) begin
        next_reserved_seen = 1'b0;
      end
    end
    if (typing_en && range_invalid) begin
      next_invalid_seen = 1'b1;
    end
    if (typing_en && range_reserved) begin
      next_reserved_seen = 1'b1;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      awready       <= 1'b1;
      wready        <= 1'b1;
      bvalid        <= 1'b0;
      bresp         <= `RESP_OKAY;
      aw_addr_q     <= `WORD_ZERO;
      w_data_q      <= `WORD_ZERO;
      w_strb_q      <= 4'h0;
      control       <= `CTRL_RESET;
      probe_field   <= `PROBE_RESET;
      invalid_seen  <= 1'b0;
      reserved_seen <= 1'b0;
    end else begin
      invalid_seen  <= next_invalid_seen;
      reserved_seen <= next_reserved_seen;
      if (awvalid && awready) begin
        awready   <= 1'b0;
        aw_addr_q <= awaddr;
      end
      if (wvalid && wready) begin
        wready   <= 1'b0;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      if (write_fire) begin
        bvalid <= 1'b1;
        bresp  <= write_hit ? `RESP_OKAY : `RESP_SLVERR;
        case (aw_addr_q & `WORD_LSB_MASK)
          `OFF_CONTROL:     control     <= control_word[`CTRL_MSB:0];
          `OFF_PROBE_FIELD: probe_field <= probe_word[`PROBE_MSB:0];
          default:          control     <= control;
        endcase
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // ==================================================================
  // read channel
  always @* begin
    read_word = `WORD_ZERO;
    read_hit  = 1'b1;
    case (araddr & `WORD_LSB_MASK)
      `OFF_CONTROL: begin
        read_word[`CTRL_MSB:0] = control;
      end
      `OFF_STATUS: begin
        read_word[`STAT_TYPE_MSB:`STAT_TYPE_LSB] = effective_type;
        read_word[`STAT_CACHEABLE]               = access_cacheable;
        read_word[`STAT_INVALID_NOW]             = invalid_encoding;
        read_word[`STAT_RESERVED_NOW]            = reserved_now;
        read_word[`STAT_INVALID_SEEN]            = invalid_seen;
        read_word[`STAT_RESERVED_SEEN]           = reserved_seen;
      end
      `OFF_PROBE_FIELD: begin
        read_word[`PROBE_MSB:0] = probe_field;
      end
      `OFF_PROBE_RESULT: begin
        read_word[`RES_TYPE_MSB:`RES_TYPE_LSB] = probe_code;
        read_word[`RES_INVALID]                = probe_invalid;
        read_word[`RES_RESERVED]               = probe_reserved;
        read_word[`RES_READ_MEM]               = probe_read_sel;
        read_word[`RES_WRITE_MEM]              = probe_write_sel;
        read_word[`RES_EXTENDED]               = probe_extended;
      end
      default: begin
        read_hit = 1'b0;
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= `WORD_ZERO;
      rresp   <= `RESP_OKAY;
    end else begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rdata   <= read_word;
        rresp   <= read_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (rvalid && rready) begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

endmodule // memory_type_field_decoder

// ### dv/decoder_props.sv
// checker: attribute relations and read answer timing
// assumes a bind onto memory_type_field_decoder, one aclk domain
`timescale 1ns/1ns
module decoder_props (
  input logic       aclk,
  input logic       aresetn,
  input logic       arvalid,
  input logic       arready,
  input logic       rvalid,
  input logic [7:0] range_type_field,
  input logic       range_is_fixed,
  input logic [2:0] effective_type,
  input logic       access_cacheable,
  input logic       write_combine_allowed,
  input logic       speculative_read_allowed,
  input logic       read_miss_allocate,
  input logic       write_miss_allocate,
  input logic       read_alloc_any_state,
  input logic       write_hit_updates_memory,
  input logic       write_hit_invalidates,
  input logic       read_to_memory_select,
  input logic       write_to_memory_select,
  input logic       invalid_encoding
);
  // ==================================================================
  // helpers
  logic [7:0] prev_field;
  always @(posedge aclk) prev_field <= range_type_field;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence read_taken; arvalid && arready; endsequence
  sequence answer_held; rvalid && !arready; endsequence
  // ==================================================================
  // relations
  a_read_answer: assert property (read_taken |=> answer_held) else $error("read answer late");
  a_uncached_none: assert property (effective_type == 3'h0 |->
    !(access_cacheable || write_combine_allowed || speculative_read_allowed)) else $error("type 0 attrs");
  a_combine_attrs: assert property (effective_type == 3'h1 |->
    write_combine_allowed && speculative_read_allowed && !access_cacheable) else $error("type 1 attrs");
  a_through_policy: assert property (access_cacheable && effective_type == 3'h4 |->
    read_miss_allocate && !write_miss_allocate && write_hit_updates_memory) else $error("type 4 policy");
  a_wp_policy: assert property (access_cacheable && effective_type == 3'h5 |->
    write_hit_invalidates && write_hit_updates_memory && !write_miss_allocate) else $error("wp policy");
  a_back_policy: assert property (access_cacheable && effective_type == 3'h6 |->
    write_miss_allocate && read_alloc_any_state) else $error("type 6 policy");
  a_cacheable_types: assert property (access_cacheable |->
    effective_type inside {3'h4, 3'h5, 3'h6}) else $error("cacheable type");
  a_invalid_source: assert property (invalid_encoding |->
    effective_type == 3'h0 && prev_field[2:0] inside {3'h2, 3'h3, 3'h7}) else $error("invalid flag");
  a_variable_standard: assert property (!$past(range_is_fixed) |->
    !(read_to_memory_select || write_to_memory_select)) else $error("variable selects");
  a_select_bits: assert property ((read_to_memory_select || write_to_memory_select) |->
    {read_to_memory_select, write_to_memory_select} == prev_field[4:3]) else $error("select bits");
endmodule // decoder_props

bind memory_type_field_decoder decoder_props chk_i (.aclk, .aresetn, .arvalid, .arready, .rvalid,
  .range_type_field, .range_is_fixed, .effective_type, .access_cacheable, .write_combine_allowed,
  .speculative_read_allowed, .read_miss_allocate, .write_miss_allocate, .read_alloc_any_state,
  .write_hit_updates_memory, .write_hit_invalidates, .read_to_memory_select, .write_to_memory_select,
  .invalid_encoding);

// ### dv/range_source.sv
// far-side model: range register source and page type feed
// assumes want_ inputs change just after a rising edge
`timescale 1ns/1ns
module range_source (
  input  logic       aclk,
  input  logic       aresetn,
  input  logic [7:0] want_field,
  input  logic       want_fixed,
  input  logic       want_ext,
  input  logic [3:0] want_page,
  output logic [7:0] range_type_field,
  output logic       range_is_fixed,
  output logic [2:0] page_type,
  output logic       page_type_valid
);
  always @(posedge aclk) begin
    if (!aresetn) begin
      range_type_field <= 8'h00;
      range_is_fixed <= 1'b0;
      page_type <= 3'h0;
      page_type_valid <= 1'b0;
    end else begin
      // software zeroes the bits reserved in the encoding it uses
      range_type_field <= want_ext ? {3'h0, want_field[4:0]} : {5'h00, want_field[2:0]};
      range_is_fixed <= want_fixed;
      page_type <= want_page[2:0];
      page_type_valid <= want_page[3];
    end
  end
endmodule // range_source

// ### dv/memory_type_field_decoder_test.sv
// bench: axi4-lite register tasks, decode and precedence checks
// assumes the register map of decoder_map.vh
`timescale 1ns/1ns
`include "decoder_map.vh"
module memory_type_field_decoder_test;
  logic        aclk = 0, aresetn = 0;
  logic [31:0] awaddr = 0, wdata = 0, araddr = 0;
  logic [3:0]  wstrb = 0, want_page = 0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0]  want_field = 0;
  logic        want_fixed = 0, want_ext = 0;
  wire         awready, wready, bvalid, arready, rvalid, range_is_fixed, page_type_valid;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire  [7:0]  range_type_field;
  wire  [2:0]  page_type, effective_type;
  wire         cach, wcomb, spec, rma, wma, rany, whu, whi, rsel, wsel, inval;
  wire  [31:0] attrs = {24'h0, cach, wcomb, spec, rma, wma, rany, whu, whi};
  int          fail_count = 0, samples_checked = 0;
  logic [9:0]  m [5] = '{{3'h6, 4'hc, 3'h4}, {3'h4, 4'hd, 3'h5}, {3'h5, 4'h9, 3'h1},
    {3'h1, 4'h8, 3'h0}, {3'h6, 4'h0, 3'h6}};

  always #10 aclk = ~aclk;

  range_source far_i (.aclk, .aresetn, .want_field, .want_fixed, .want_ext, .want_page, .range_type_field,
    .range_is_fixed, .page_type, .page_type_valid);
  memory_type_field_decoder uut (.aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .range_type_field, .range_is_fixed, .page_type, .page_type_valid, .effective_type,
    .access_cacheable(cach), .write_combine_allowed(wcomb), .speculative_read_allowed(spec), .read_miss_allocate(rma),
    .write_miss_allocate(wma), .read_alloc_any_state(rany), .write_hit_updates_memory(whu),
    .write_hit_invalidates(whi), .read_to_memory_select(rsel), .write_to_memory_select(wsel),
    .invalid_encoding(inval));

  // ==================================================================
  // tasks
  task automatic report_and_stop;
    if (fail_count == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic axi_write(input logic [31:0] a, d, output logic [1:0] resp);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        resp = bresp;
        bready <= 1'b0;
        break;
      end
    end
    if (n == 40) begin
      fail_count++;
      report_and_stop();
    end
  endtask
  task automatic axi_read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] resp);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
        break;
      end
    end
    if (n == 40) begin
      fail_count++;
      report_and_stop();
    end
  endtask
  // model edge, decoder edge, one spare
  task automatic apply(input logic [7:0] f, input logic fx, ex, input logic [3:0] pg);
    @(posedge aclk);
    want_field <= f;
    want_fixed <= fx;
    want_ext <= ex;
    want_page <= pg;
    repeat (3) @(posedge aclk);
    #1;
  endtask
  function automatic logic [31:0] policy(input logic [2:0] t, input logic c);
    logic a;
    a = c && t inside {3'h4, 3'h5, 3'h6};
    return {24'h0, a, t == 3'h1, t != 3'h0, a, a && t == 3'h6, a && t == 3'h6, t inside {3'h4, 3'h5}, a && t == 3'h5};
  endfunction
  task automatic check_out(input logic [2:0] t, input logic c, iv, input logic [1:0] sel);
    chk("effective_type", {29'h0, t}, {29'h0, effective_type});
    chk("attributes", policy(t, c), attrs);
    chk("invalid_encoding", {31'h0, iv}, {31'h0, inval});
    chk("selects", {30'h0, sel}, {30'h0, rsel, wsel});
  endtask

  // ==================================================================
  // sequence
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [2:0]  t;
    logic        iv;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    axi_read(`OFF_CONTROL, d, r);
    chk("control reset", 32'h0, d);
    apply(8'h06, 1'b0, 1'b0, 4'h0);
    check_out(3'h0, 1'b0, 1'b0, 2'h0);
    axi_write(`OFF_CONTROL, 32'h3, r);
    chk("bresp", {30'h0, `RESP_OKAY}, {30'h0, r});
    for (int c = 0; c < 8; c++) begin
      t = c[2:0];
      iv = t inside {3'h2, 3'h3, 3'h7};
      apply({3'h0, t[1:0], t}, 1'b1, 1'b1, 4'h0);
      check_out(iv ? 3'h0 : t, 1'b1, iv, t[1:0]);
    end
    apply(8'h1e, 1'b0, 1'b1, 4'h0);
    check_out(`TYPE_WRITE_BACK, 1'b1, 1'b0, 2'h0);
    axi_write(`OFF_CONTROL, 32'h1, r);
    apply(8'h1e, 1'b1, 1'b1, 4'h0);
    check_out(`TYPE_WRITE_BACK, 1'b1, 1'b0, 2'h0);
    axi_write(`OFF_CONTROL, 32'h5, r);
    apply(8'h06, 1'b0, 1'b0, 4'h0);
    check_out(`TYPE_WRITE_BACK, 1'b0, 1'b0, 2'h0);
    axi_write(`OFF_CONTROL, 32'h9, r);
    foreach (m[i]) begin
      apply({5'h0, m[i][9:7]}, 1'b0, 1'b0, m[i][6:3]);
      check_out(m[i][2:0], 1'b1, 1'b0, 2'h0);
    end
    axi_write(`OFF_CONTROL, 32'h1, r);
    apply(8'h07, 1'b0, 1'b0, 4'h0);
    check_out(3'h0, 1'b1, 1'b1, 2'h0);
    axi_read(`OFF_STATUS, d, r);
    chk("status sticky", 32'h310, d);
    apply(8'h06, 1'b0, 1'b0, 4'h0);
    axi_write(`OFF_STATUS, 32'h300, r);
    axi_read(`OFF_STATUS, d, r);
    chk("status cleared", 32'h0e, d);
    axi_write(`OFF_PROBE_FIELD, 32'hfffff11d, r);
    axi_read(`OFF_PROBE_FIELD, d, r);
    chk("probe field", 32'h11d, d);
    axi_read(`OFF_PROBE_RESULT, d, r);
    chk("probe result", 32'h15, d);
    axi_write(32'h10, 32'h1, r);
    chk("unmapped bresp", {30'h0, `RESP_SLVERR}, {30'h0, r});
    axi_read(32'h10, d, r);
    chk("unmapped rresp", {30'h0, `RESP_SLVERR}, {30'h0, r});
    chk("unmapped rdata", 32'h0, d);
    report_and_stop();
  end
endmodule // memory_type_field_decoder_test
